// file: wtc_pkg.sv
// Constants, types and mode helpers for the wide timer control block.
// Assumes a single 40 MHz system clock and an APB register port.
package wtc_pkg;

  localparam int          CH_N       = 3;
  localparam int          FILT_LEN   = 4;
  localparam logic [7:0]  OFF_CTRL_A = 8'h00;
  localparam logic [7:0]  OFF_CTRL_B = 8'h04;
  localparam logic [7:0]  OFF_CTRL_C = 8'h08;
  localparam logic [7:0]  OFF_COUNT  = 8'h0C;
  localparam logic [7:0]  OFF_CMP_A  = 8'h10;
  localparam logic [7:0]  OFF_CMP_B  = 8'h14;
  localparam logic [7:0]  OFF_CMP_C  = 8'h18;
  localparam logic [7:0]  OFF_CAPT   = 8'h1C;
  localparam logic [7:0]  OFF_FLAGS  = 8'h20;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_B_WMASK = 8'hDF;
  localparam int          FLG_OVF    = 0;
  localparam int          FLG_CMP    = 1;
  localparam int          FLG_CAP    = 5;
  localparam logic [5:0]  FLAGS_RST  = 6'h00;
  localparam logic [15:0] TOP_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8      = 16'h00FF;
  localparam logic [15:0] TOP_9      = 16'h01FF;
  localparam logic [15:0] TOP_10     = 16'h03FF;
  localparam logic [9:0]  PS_8       = 10'h007;
  localparam logic [9:0]  PS_64      = 10'h03F;
  localparam logic [9:0]  PS_256     = 10'h0FF;
  localparam logic [9:0]  PS_1024    = 10'h3FF;
  localparam logic [2:0]  CS_OFF     = 3'h0;
  localparam logic [2:0]  CS_DIV1    = 3'h1;
  localparam logic [2:0]  CS_DIV8    = 3'h2;
  localparam logic [2:0]  CS_DIV64   = 3'h3;
  localparam logic [2:0]  CS_DIV256  = 3'h4;
  localparam logic [2:0]  CS_DIV1024 = 3'h5;
  localparam logic [2:0]  CS_FALL    = 3'h6;
  localparam logic [2:0]  CS_RISE    = 3'h7;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } wtc_apb_req_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } wtc_dir_t;

  // Normal, clear-on-match and reserved modes
  function automatic logic wtc_non_pwm(input logic [3:0] m);
    return (m == 4'h0) || (m == 4'h4) || (m == 4'hC) || (m == 4'hD);
  endfunction : wtc_non_pwm

  function automatic logic wtc_phase(input logic [3:0] m);
    return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
  endfunction : wtc_phase

  function automatic logic wtc_bot_load(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'h9);
  endfunction : wtc_bot_load

  function automatic logic wtc_capt_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction : wtc_capt_top

  function automatic logic wtc_cmpa_top(input logic [3:0] m);
    return (m == 4'h4) || (m == 4'h9) || (m == 4'hB) || (m == 4'hF);
  endfunction : wtc_cmpa_top

  function automatic logic wtc_fast_tgl(input logic [3:0] m);
    return (m == 4'hE) || (m == 4'hF);
  endfunction : wtc_fast_tgl

endpackage : wtc_pkg

// file: wtc_timer.sv
// 16-bit timer with three compare channels, mode, clock and capture control.
// Assumes an APB master on clk_sys_in; all pin inputs synchronous to it.
// Function
// - Four-bit waveform mode from control A bits 1:0 and B bits 4:3.
// - Modes 0, 4, 12: TOP FFFF/compare A/capture, immediate load, flag at MAX.
// - Phase modes 1-3, 10, 11: load at TOP, overflow flag at BOTTOM.
// - Modes 8, 9: TOP capture or compare A, load and flag at BOTTOM.
// - Fast modes 5-7, 14, 15: load at TOP, overflow flag at TOP.
// - Filter needs four equal capture pin samples before level changes.
// - Edge select zero means falling, one means rising capture edge.
// - Capture copies counter to capture value and sets capture flag.
// - No captures while capture value serves as TOP.
// - Clock select 1 undivided; 2 to 5 divide by 8, 64, 256, 1024.
// - Clock select 0 stops the counter.
// - Code 6 counts falling, code 7 rising count pin edges.
// - Count pin edges count regardless of the pin's direction setting.
// - Force bits act only in non-PWM modes.
// - Force applies an immediate match using the channel output action.
// - Force sets no flag and never clears the counter.
// - Non-PWM action: 00 off, 01 toggle, 10 low, 11 high.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module wtc_timer
  import wtc_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               nrst_in,
  input  wire wtc_apb_req_t       apb_req_in,
  output logic [31:0]             prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  input  wire logic               ext_count_pin_in,
  input  wire logic               capture_pin_in,
  output logic [CH_N-1:0]         wave_out_pin_out,
  output logic [CH_N-1:0]         wave_out_en_out
);

  logic [7:0]             control_reg_a;
  logic [7:0]             control_reg_b;
  logic [15:0]            counter_value;
  logic [15:0]            capture_value;
  logic [15:0]            cmp_buf [CH_N];
  logic [15:0]            cmp_act [CH_N];
  logic [15:0]            cmp_eff [CH_N];
  logic [5:0]             flags;
  logic [9:0]             presc;
  logic                   ext_q;
  logic [FILT_LEN-1:0]    cap_samp;
  logic                   cap_lvl;
  logic                   cap_lvl_q;
  logic                   block_match;
  wtc_dir_t               dir;
  logic [CH_N-1:0]        wave;
  logic [3:0]             waveform_mode_sel;
  logic [2:0]             clock_sel;
  logic                   capture_filter_en;
  logic                   capture_edge_sel;
  logic                   non_pwm;
  logic                   phase;
  logic [15:0]            top;
  logic                   tick;
  logic                   at_top;
  logic                   at_bot;
  logic                   ovf_ev;
  logic                   load_ev;
  logic                   cap_ev;
  logic [CH_N-1:0]        match;
  logic [CH_N-1:0]        force_match;
  logic                   acc;
  logic                   wr;
  logic                   hit;
  logic [31:0]            next_rdata;

  // Control field decode
  assign waveform_mode_sel = {control_reg_b[4:3], control_reg_a[1:0]};
  assign clock_sel         = control_reg_b[2:0];
  assign capture_filter_en = control_reg_b[7];
  assign capture_edge_sel  = control_reg_b[6];
  assign non_pwm           = wtc_non_pwm(waveform_mode_sel);
  assign phase             = wtc_phase(waveform_mode_sel);

  // APB decode, zero wait states
  assign acc         = apb_req_in.psel & apb_req_in.penable;
  assign wr          = acc & apb_req_in.pwrite;
  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~hit;

  always_comb begin
    hit        = 1'b1;
    next_rdata = 32'h0000_0000;
    case (apb_req_in.paddr)
      OFF_CTRL_A: next_rdata = {24'h00_0000, control_reg_a};
      OFF_CTRL_B: next_rdata = {24'h00_0000, control_reg_b};
      OFF_CTRL_C: next_rdata = 32'h0000_0000;
      OFF_COUNT:  next_rdata = {16'h0000, counter_value};
      OFF_CMP_A:  next_rdata = {16'h0000, cmp_buf[0]};
      OFF_CMP_B:  next_rdata = {16'h0000, cmp_buf[1]};
      OFF_CMP_C:  next_rdata = {16'h0000, cmp_buf[2]};
      OFF_CAPT:   next_rdata = {16'h0000, capture_value};
      OFF_FLAGS:  next_rdata = {26'h000_0000, flags};
      default:    hit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_req_in.psel && !apb_req_in.penable) begin
      prdata_out <= next_rdata;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      control_reg_a <= CTRL_RST;
      control_reg_b <= CTRL_RST;
    end else if (wr && apb_req_in.paddr == OFF_CTRL_A) begin
      control_reg_a <= apb_req_in.pwdata[7:0];
    end else if (wr && apb_req_in.paddr == OFF_CTRL_B) begin
      control_reg_b <= apb_req_in.pwdata[7:0] & CTRL_B_WMASK;
    end
  end

  // Force strobes, only honoured in non-PWM modes
  always_comb begin
    force_match = '0;
    if (wr && apb_req_in.paddr == OFF_CTRL_C && non_pwm) begin
      force_match = {apb_req_in.pwdata[5], apb_req_in.pwdata[6], apb_req_in.pwdata[7]};
    end
  end

  // Prescaler and clock source
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      presc <= 10'h000;
      ext_q <= 1'b0;
    end else begin
      presc <= presc + 10'h001;
      ext_q <= ext_count_pin_in;
    end
  end

  always_comb begin
    case (clock_sel)
      CS_OFF:     tick = 1'b0;
      CS_DIV1:    tick = 1'b1;
      CS_DIV8:    tick = (presc & PS_8) == PS_8;
      CS_DIV64:   tick = (presc & PS_64) == PS_64;
      CS_DIV256:  tick = (presc & PS_256) == PS_256;
      CS_DIV1024: tick = (presc & PS_1024) == PS_1024;
      CS_FALL:    tick = ext_q & ~ext_count_pin_in;
      CS_RISE:    tick = ~ext_q & ext_count_pin_in;
      default:    tick = 1'b0;
    endcase
  end

  // TOP selection
  always_comb begin
    case (waveform_mode_sel)
      4'h1, 4'h5: top = TOP_8;
      4'h2, 4'h6: top = TOP_9;
      4'h3, 4'h7: top = TOP_10;
      default: begin
        if (wtc_capt_top(waveform_mode_sel)) begin
          top = capture_value;
        end else if (wtc_cmpa_top(waveform_mode_sel)) begin
          top = cmp_eff[0];
        end else begin
          top = TOP_MAX;
        end
      end
    endcase
  end

  assign at_top  = counter_value == top;
  assign at_bot  = counter_value == 16'h0000;
  assign load_ev = tick & ~non_pwm
                 & (wtc_bot_load(waveform_mode_sel) ? at_bot : at_top);
  always_comb begin
    if (non_pwm) begin
      ovf_ev = tick & (counter_value == TOP_MAX);
    end else if (phase) begin
      ovf_ev = tick & at_bot;
    end else begin
      ovf_ev = tick & at_top;
    end
  end

  // Counter and direction
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      counter_value <= 16'h0000;
      dir           <= DIR_UP;
    end else if (wr && apb_req_in.paddr == OFF_COUNT) begin
      counter_value <= apb_req_in.pwdata[15:0];
    end else if (tick) begin
      if (phase) begin
        case (dir)
          DIR_UP: begin
            if (counter_value >= top) begin
              dir           <= DIR_DOWN;
              counter_value <= counter_value - 16'h0001;
            end else begin
              counter_value <= counter_value + 16'h0001;
            end
          end
          DIR_DOWN: begin
            if (at_bot) begin
              dir           <= DIR_UP;
              counter_value <= counter_value + 16'h0001;
            end else begin
              counter_value <= counter_value - 16'h0001;
            end
          end
          default: dir <= DIR_UP;
        endcase
      end else begin
        dir <= DIR_UP;
        // Clear-on-match wraps at TOP; forces never reach here
        if (counter_value >= top) begin
          counter_value <= 16'h0000;
        end else begin
          counter_value <= counter_value + 16'h0001;
        end
      end
    end
  end

  // Counter write suppresses the next timer clock's match
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      block_match <= 1'b0;
    end else if (wr && apb_req_in.paddr == OFF_COUNT) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // Compare buffers and active values
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < CH_N; i++) begin
        cmp_buf[i] <= 16'h0000;
        cmp_act[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        if (wr && apb_req_in.paddr == OFF_CMP_A + 8'(4 * i)) begin
          cmp_buf[i] <= apb_req_in.pwdata[15:0];
        end
        if (non_pwm || load_ev) begin
          cmp_act[i] <= cmp_buf[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      cmp_eff[i] = non_pwm ? cmp_buf[i] : cmp_act[i];
      match[i]   = tick & ~block_match & (counter_value == cmp_eff[i]);
    end
  end

  // Waveform outputs
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wave <= '0;
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        if (non_pwm) begin
          if (match[i] || force_match[i]) begin
            case (control_reg_a[7-2*i -: 2])
              2'b01:   wave[i] <= ~wave[i];
              2'b10:   wave[i] <= 1'b0;
              2'b11:   wave[i] <= 1'b1;
              default: wave[i] <= wave[i];
            endcase
          end
        end else if (control_reg_a[7-2*i]) begin
          if (phase) begin
            if (match[i]) begin
              wave[i] <= (dir == DIR_UP) ? control_reg_a[6-2*i] : ~control_reg_a[6-2*i];
            end
          end else if (tick && at_top) begin
            wave[i] <= ~control_reg_a[6-2*i];
          end else if (match[i]) begin
            wave[i] <= control_reg_a[6-2*i];
          end
        end else if (control_reg_a[6-2*i] && i == 0 && match[i]
                     && (phase ? wtc_bot_load(waveform_mode_sel) || waveform_mode_sel[3]
                               : wtc_fast_tgl(waveform_mode_sel))) begin
          wave[i] <= ~wave[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      if (non_pwm || control_reg_a[7-2*i]) begin
        wave_out_en_out[i] = control_reg_a[7-2*i -: 2] != 2'b00;
      end else begin
        wave_out_en_out[i] = control_reg_a[6-2*i] && i == 0
                             && (phase ? waveform_mode_sel[3]
                                       : wtc_fast_tgl(waveform_mode_sel));
      end
    end
  end

  assign wave_out_pin_out = wave;

  // Capture filter and edge detect
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      cap_samp  <= '0;
      cap_lvl   <= 1'b0;
      cap_lvl_q <= 1'b0;
    end else begin
      cap_samp  <= {cap_samp[FILT_LEN-2:0], capture_pin_in};
      cap_lvl_q <= cap_lvl;
      if (!capture_filter_en) begin
        cap_lvl <= capture_pin_in;
      end else if (&cap_samp) begin
        cap_lvl <= 1'b1;
      end else if (~|cap_samp) begin
        cap_lvl <= 1'b0;
      end
    end
  end

  assign cap_ev = (cap_lvl != cap_lvl_q) && (cap_lvl == capture_edge_sel)
                  && !wtc_capt_top(waveform_mode_sel);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      capture_value <= 16'h0000;
    end else if (cap_ev) begin
      capture_value <= counter_value;
    end else if (wr && apb_req_in.paddr == OFF_CAPT) begin
      capture_value <= apb_req_in.pwdata[15:0];
    end
  end

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      flags <= FLAGS_RST;
    end else begin
      for (int b = 0; b < 6; b++) begin
        if (wr && apb_req_in.paddr == OFF_FLAGS && apb_req_in.pwdata[b]) begin
          flags[b] <= 1'b0;
        end
      end
      if (ovf_ev) begin
        flags[FLG_OVF] <= 1'b1;
      end
      for (int i = 0; i < CH_N; i++) begin
        if (match[i]) begin
          flags[FLG_CMP+i] <= 1'b1;
        end
      end
      if (cap_ev) begin
        flags[FLG_CAP] <= 1'b1;
      end
    end
  end

endmodule : wtc_timer

// file: wtc_timer_checker.sv
// Port checker for the wide timer control block.
// Assumes binding to wtc_timer; control state shadowed from APB writes.
`timescale 1ns/1ps
module wtc_timer_checker
  import wtc_pkg::*;
(
  input wire logic            clk_sys_in,
  input wire logic            nrst_in,
  input wire wtc_apb_req_t    apb_req_in,
  input wire logic [31:0]     prdata_out,
  input wire logic            pready_out,
  input wire logic            pslverr_out,
  input wire logic            ext_count_pin_in,
  input wire logic            capture_pin_in,
  input wire logic [CH_N-1:0] wave_out_pin_out,
  input wire logic [CH_N-1:0] wave_out_en_out
);
  logic [7:0]  sh_a;
  logic [7:0]  sh_b;
  logic [15:0] last;
  logic        ok;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [3:0]  md;
  logic [7:0]  ad;
  assign ad = apb_req_in.paddr;
  assign wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
  assign rd = apb_req_in.psel && apb_req_in.penable && !apb_req_in.pwrite;
  assign md = {sh_b[4:3], sh_a[1:0]};
  assign mapped = ad inside {OFF_CTRL_A, OFF_CTRL_B, OFF_CTRL_C, OFF_COUNT,
                             OFF_CMP_A, OFF_CMP_B, OFF_CMP_C, OFF_CAPT, OFF_FLAGS};
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Shadow of control A and B
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sh_a <= CTRL_RST;
      sh_b <= CTRL_RST;
    end else if (wr && ad == OFF_CTRL_A) begin
      sh_a <= apb_req_in.pwdata[7:0];
    end else if (wr && ad == OFF_CTRL_B) begin
      sh_b <= apb_req_in.pwdata[7:0];
    end
  end
  // Last counter value read while stopped
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || sh_b[2:0] != CS_OFF || (wr && ad == OFF_COUNT)) begin
      ok <= 1'b0;
    end else if (rd && ad == OFF_COUNT) begin
      ok   <= 1'b1;
      last <= prdata_out[15:0];
    end
  end
  sequence force_a_s;
    wr && ad == OFF_CTRL_C && apb_req_in.pwdata[7];
  endsequence
  sequence quiet_s;
    wtc_non_pwm(md) && sh_b[2:0] == CS_OFF && sh_a[7];
  endsequence
  ready_high_a: assert property (pready_out)
    else $error("pready low");
  unmapped_err_a: assert property (rd && !mapped |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (apb_req_in.psel && mapped |-> !pslverr_out)
    else $error("mapped access refused");
  ctrl_a_read_a: assert property (rd && ad == OFF_CTRL_A |-> prdata_out == {24'h0, sh_a})
    else $error("control A readback wrong");
  ctrl_b_read_a: assert property (rd && ad == OFF_CTRL_B |-> prdata_out == {24'h0, sh_b & CTRL_B_WMASK})
    else $error("control B readback wrong");
  force_zero_a: assert property (rd && ad == OFF_CTRL_C |-> prdata_out == 32'h0)
    else $error("control C not zero");
  stop_hold_a: assert property (rd && ad == OFF_COUNT && ok |-> prdata_out[15:0] == last)
    else $error("stopped counter moved");
  enable_map_a: assert property (wtc_non_pwm(md) |->
      wave_out_en_out == {|sh_a[3:2], |sh_a[5:4], |sh_a[7:6]})
    else $error("output enable wrong");
  force_level_a: assert property (force_a_s ##0 quiet_s |->
      ##[1:2] wave_out_pin_out[0] == sh_a[6])
    else $error("forced level wrong");
endmodule : wtc_timer_checker

// file: wtc_pin_model.sv
// Pin-side partner: drives the count and capture pins.
// Assumes levels requested by the bench; changes just after clock edges.
`timescale 1ns/1ps
module wtc_pin_model (
  input  wire logic clk_sys_in,
  input  wire logic cnt_lvl_in,
  input  wire logic cap_lvl_in,
  output logic      ext_count_pin_out = 1'b0,
  output logic      capture_pin_out = 1'b0
);
  // Synchronous source, one edge behind the request
  always @(posedge clk_sys_in) begin
    ext_count_pin_out <= cnt_lvl_in;
    capture_pin_out   <= cap_lvl_in;
  end
endmodule : wtc_pin_model

// file: test_wtc_timer.sv
// Self-checking bench for the wide timer control block.
// Assumes zero-wait APB slave and the pin model as signal source.
`timescale 1ns/1ps
module test_wtc_timer;
  import wtc_pkg::*;
  logic         clk_sys_in = 1'b0;
  logic         nrst_in = 1'b0;
  wtc_apb_req_t req = '0;
  logic [31:0]  prdata;
  logic [31:0]  rv;
  logic [31:0]  base;
  logic         pready;
  logic         pslverr;
  logic         ev;
  logic         cnt_lvl = 1'b0;
  logic         cap_lvl = 1'b0;
  logic         ext_pin;
  logic         cap_pin;
  logic [2:0]   wave;
  logic [2:0]   wen;
  logic [2:0]   exp;
  int           fails = 0;
  int           num_checks = 0;
  int           cyc = 0;
  int           dv[6] = '{0, 0, 3, 6, 8, 10};
  logic [3:0]   mds[15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                            4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
  logic [15:0]  tops[15] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF, 16'h0100, 16'h00FF,
                             16'h01FF, 16'h03FF, 16'h0080, 16'h0100, 16'h0080, 16'h0100,
                             16'h0080, 16'h0080, 16'h0100};
  always #12.5 clk_sys_in = ~clk_sys_in;
  wtc_timer i_wtc_timer (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .apb_req_in(req),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ext_count_pin_in(ext_pin), .capture_pin_in(cap_pin),
    .wave_out_pin_out(wave), .wave_out_en_out(wen));
  wtc_pin_model i_wtc_pin_model (.clk_sys_in(clk_sys_in), .cnt_lvl_in(cnt_lvl),
    .cap_lvl_in(cap_lvl), .ext_count_pin_out(ext_pin), .capture_pin_out(cap_pin));
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    step(2);
    nrst_in <= 1'b1;
    foreach (dv[i]) begin
      rd(8'(4 * i));
      chk(rv, 32'h0);
    end
    rd(8'h24);
    chk({31'h0, ev}, 32'h1);
    chk(rv, 32'h0);
    wr(OFF_CTRL_B, 32'hDF);
    rd(OFF_CTRL_B);
    chk(rv, 32'hDF);
    wr(OFF_CTRL_C, 32'hE0);
    rd(OFF_CTRL_C);
    chk(rv, 32'h0);
    wr(OFF_CTRL_B, 32'h0);
    for (int cs = 0; cs < 6; cs++) begin
      wr(OFF_CTRL_B, cs);
      rd(OFF_COUNT);
      base = rv;
      step(2045);
      rd(OFF_COUNT);
      chk((rv - base) & 32'hFFFF, cs == 0 ? 32'h0 : 32'(2048 >> dv[cs]));
    end
    for (int cs = 6; cs < 8; cs++) begin
      step(1);
      cnt_lvl <= 1'b0;
      wr(OFF_CTRL_B, cs);
      step(4);
      rd(OFF_COUNT);
      base = rv;
      for (int k = 0; k < 11; k++) begin
        step(3);
        cnt_lvl <= ~cnt_lvl;
      end
      step(6);
      rd(OFF_COUNT);
      chk((rv - base) & 32'hFFFF, cs == 6 ? 32'h5 : 32'h6);
    end
    for (int es = 0; es < 2; es++) begin
      wr(OFF_CTRL_B, 32'h0);
      cap_lvl <= !es;
      wr(OFF_COUNT, 32'h1000 + es);
      wr(OFF_CTRL_B, es << 6);
      step(6);
      wr(OFF_FLAGS, 32'h20);
      cap_lvl <= es[0];
      step(6);
      rd(OFF_FLAGS);
      chk(rv & 32'h20, 32'h20);
      rd(OFF_CAPT);
      chk(rv, 32'h1000 + es);
      wr(OFF_FLAGS, 32'h20);
      cap_lvl <= !es;
      step(6);
      rd(OFF_FLAGS);
      chk(rv & 32'h20, 32'h0);
    end
    wr(OFF_CTRL_B, 32'hC0);
    step(8);
    wr(OFF_FLAGS, 32'h20);
    cap_lvl <= 1'b1;
    step(3);
    cap_lvl <= 1'b0;
    step(8);
    rd(OFF_FLAGS);
    chk(rv & 32'h20, 32'h0);
    cap_lvl <= 1'b1;
    step(8);
    rd(OFF_FLAGS);
    chk(rv & 32'h20, 32'h20);
    wr(OFF_CTRL_B, 32'h18);
    wr(OFF_CAPT, 32'h55);
    cap_lvl <= 1'b0;
    step(8);
    wr(OFF_FLAGS, 32'h3F);
    wr(OFF_CTRL_B, 32'h58);
    cap_lvl <= 1'b1;
    step(8);
    rd(OFF_FLAGS);
    chk(rv & 32'h20, 32'h0);
    rd(OFF_CAPT);
    chk(rv, 32'h55);
    wr(OFF_CTRL_B, 32'h08);
    exp = 3'b000;
    for (int ch = 0; ch < 3; ch++) begin
      for (int act = 3; act > 0; act--) begin
        wr(OFF_CTRL_A, act << (6 - 2 * ch));
        wr(OFF_CTRL_C, 32'h80 >> ch);
        step(3);
        exp[ch] = (act == 1) ? !exp[ch] : act[0];
        chk(32'(wave[ch]), 32'(exp[ch]));
        chk(32'(wen[ch]), 32'h1);
      end
    end
    rd(OFF_FLAGS);
    chk(rv, 32'h0);
    rd(OFF_COUNT);
    chk(rv, 32'h1001);
    wr(OFF_CTRL_A, 32'h80);
    wr(OFF_CTRL_C, 32'h80);
    wr(OFF_CTRL_A, 32'hC1);
    wr(OFF_CTRL_C, 32'h80);
    step(3);
    chk(32'(wave[0]), 32'h0);
    wr(OFF_CTRL_A, 32'h0);
    wr(OFF_CTRL_B, 32'h0);
    wr(OFF_CMP_A, 32'h100);
    wr(OFF_CAPT, 32'h80);
    foreach (mds[i]) begin
      wr(OFF_CTRL_A, 32'h0);
      wr(OFF_CTRL_B, 32'h0);
      wr(OFF_COUNT, mds[i] == 0 ? 32'hFFF0 : 32'h0);
      wr(OFF_FLAGS, 32'h3F);
      wr(OFF_CTRL_A, 32'(mds[i][1:0]));
      wr(OFF_CTRL_B, 32'({mds[i][3:2], 3'b001}));
      repeat (3) begin
        step(750);
        rd(OFF_COUNT);
        chk(32'(rv[15:0] <= tops[i]), 32'h1);
      end
      rd(OFF_FLAGS);
      chk(rv & 32'h1, 32'((mds[i] != 4) && (mds[i] != 12)));
      chk(rv & 32'h2, tops[i] >= 16'h0100 ? 32'h2 : 32'h0);
    end
    report_and_stop();
  end
endmodule : test_wtc_timer
bind wtc_timer wtc_timer_checker i_wtc_timer_checker (.clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in), .apb_req_in(apb_req_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .ext_count_pin_in(ext_count_pin_in), .capture_pin_in(capture_pin_in),
  .wave_out_pin_out(wave_out_pin_out), .wave_out_en_out(wave_out_en_out));
